// ---- i2c_slave_port.sv ----
// two-wire slave serial port: address match, auto acknowledge, rx buffer
// assumes SCL/SDA arrive asynchronously; open-drain wire resolved outside
//
// Contract
// - all slave functions except general call; start/stop interrupts offered.
// - standard mode timing, 7-bit and 10-bit slave addressing.
// - nothing happens unless the port enable is set.
// - four-bit mode field selects the operating mode.
// - modes: 7-bit, 10-bit, each with start/stop irq, irq-only idle.
// - pins driven open-drain only when enabled, mode set, directions input.
// - clock on one pin, data on another; two direction bits govern them.
// - with pins as inputs, port drives data when slave transmitter.
// - on match or data byte: acknowledge and copy shift register to buffer.
// - no acknowledge when buffer full or overflow already set.
// - on that refusal, no buffer load, but interrupt flag still set.
// - buffer read clears full; overflow stays until software clears it.
// - shift register unreachable; data only via buffer.
`timescale 1ns/1ps
module i2c_slave_port (
  input  wire logic       CLOCK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SCL_O,
  output logic            SCL_OE_O,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  input  wire logic       PORT_ENABLE_I,
  input  wire logic [3:0] MODE_I,
  input  wire logic       SCL_DIR_IN_I,
  input  wire logic       SDA_DIR_IN_I,
  input  wire logic [9:0] SLAVE_ADDR_I,
  input  wire logic [7:0] TX_DATA_I,
  input  wire logic       TX_LOAD_I,
  output logic      [7:0] RX_DATA_O,
  output logic            RX_VALID_O,
  input  wire logic       RX_READY_I,
  output logic            BUFFER_FULL_O,
  output logic            OVERFLOW_O,
  input  wire logic       OVF_CLR_I,
  output logic            IRQ_FLAG_O,
  input  wire logic       IRQ_CLR_I,
  output logic            START_SEEN_O,
  output logic            STOP_SEEN_O
);
  // mode decoders, shared by engine and pin gating
  function automatic logic is_slave(input logic [3:0] m);
    return (m == i2c_port_pkg::MODE_SLV7)    || (m == i2c_port_pkg::MODE_SLV10) ||
           (m == i2c_port_pkg::MODE_SLV7_SS) || (m == i2c_port_pkg::MODE_SLV10_SS);
  endfunction
  function automatic logic is_ten(input logic [3:0] m);
    return (m == i2c_port_pkg::MODE_SLV10) || (m == i2c_port_pkg::MODE_SLV10_SS);
  endfunction
  function automatic logic has_ss(input logic [3:0] m);
    return (m == i2c_port_pkg::MODE_SLV7_SS) || (m == i2c_port_pkg::MODE_SLV10_SS) ||
           (m == i2c_port_pkg::MODE_SS_ONLY);
  endfunction

  logic [1:0] pins_s;
  logic       scl_s, sda_s, scl_q, sda_q;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic       active, pins_ok;
  i2c_port_pkg::state_t state_r, state_nxt, after_r, after_nxt;
  logic [7:0] shift_r, shift_nxt, txsh_r, txsh_nxt, txbuf_r, txbuf_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       drive_r, drive_nxt, hi_match_r, hi_match_nxt;
  logic       ovf_r, ovf_nxt, irq_r, irq_nxt, ss_r, ss_nxt, sp_r, sp_nxt;
  logic       take, push, fifo_ready, rd_bit, addr_ok;

  // pins pass two flops before any logic reads them
  bit_sync #(.W(i2c_port_pkg::SYNC_STAGES)) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (SYS_RST_I),
    .d_i   ({SCL_I, SDA_I}),
    .q_o   (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // edge and bus condition detect on synchronised levels
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign active    = PORT_ENABLE_I & is_slave(MODE_I);
  assign pins_ok   = SCL_DIR_IN_I & SDA_DIR_IN_I;

  // received bytes queue; full means software has not read
  rx_buffer #(.W(i2c_port_pkg::DATA_W), .DEPTH(i2c_port_pkg::RX_DEPTH)) u_rxbuf (
    .clk_i       (CLOCK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (shift_r),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .out_data_o  (RX_DATA_O),
    .out_valid_o (RX_VALID_O),
    .out_ready_i (RX_READY_I)
  );
  assign BUFFER_FULL_O = ~fifo_ready;

  // address compare against the configured slave address
  always_comb begin
    rd_bit  = shift_r[0];
    addr_ok = 1'b0;
    if (state_r == i2c_port_pkg::ST_ADDR2) begin
      addr_ok = (shift_r == SLAVE_ADDR_I[7:0]);
    end else if (is_ten(MODE_I)) begin
      addr_ok = (shift_r[7:3] == i2c_port_pkg::ADDR10_PREFIX) &&
                (shift_r[2:1] == SLAVE_ADDR_I[9:8]) && (!rd_bit || hi_match_r);
    end else begin
      addr_ok = (shift_r[7:1] == SLAVE_ADDR_I[6:0]);
    end
  end

  // protocol engine next state; no general call match here
  always_comb begin
    state_nxt    = state_r;
    after_nxt    = after_r;
    shift_nxt    = shift_r;
    txsh_nxt     = txsh_r;
    cnt_nxt      = cnt_r;
    drive_nxt    = drive_r;
    hi_match_nxt = hi_match_r;
    take         = 1'b0;
    push         = 1'b0;
    if (!active) begin
      state_nxt    = i2c_port_pkg::ST_IDLE;
      drive_nxt    = 1'b0;
      hi_match_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = i2c_port_pkg::ST_ADDR;
      cnt_nxt   = i2c_port_pkg::CNT_RST;
      drive_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt    = i2c_port_pkg::ST_IDLE;
      drive_nxt    = 1'b0;
      hi_match_nxt = 1'b0;
    end else begin
      case (state_r)
        i2c_port_pkg::ST_ADDR, i2c_port_pkg::ST_ADDR2, i2c_port_pkg::ST_RX: begin
          if (scl_rise && cnt_r != i2c_port_pkg::BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == i2c_port_pkg::BYTE_BITS) begin
            if (state_r == i2c_port_pkg::ST_RX || addr_ok) begin
              take      = 1'b1;
              state_nxt = i2c_port_pkg::ST_ACK;
              if (state_r == i2c_port_pkg::ST_RX) begin
                after_nxt = i2c_port_pkg::ST_RX;
              end else if (state_r == i2c_port_pkg::ST_ADDR2) begin
                after_nxt    = i2c_port_pkg::ST_RX;
                hi_match_nxt = 1'b1;
              end else if (rd_bit) begin
                after_nxt = i2c_port_pkg::ST_TX;
              end else if (is_ten(MODE_I)) begin
                after_nxt = i2c_port_pkg::ST_ADDR2;
              end else begin
                after_nxt = i2c_port_pkg::ST_RX;
              end
              if (!fifo_ready || ovf_r) begin
                drive_nxt = 1'b0;
                after_nxt = i2c_port_pkg::ST_WAIT;
              end else begin
                drive_nxt = 1'b1;
                push      = 1'b1;
              end
            end else begin
              state_nxt = i2c_port_pkg::ST_WAIT;
            end
          end
        end
        i2c_port_pkg::ST_ACK: begin
          if (scl_fall) begin
            drive_nxt = 1'b0;
            state_nxt = after_r;
            cnt_nxt   = i2c_port_pkg::CNT_RST;
            if (after_r == i2c_port_pkg::ST_TX) begin
              txsh_nxt  = txbuf_r;
              drive_nxt = ~txbuf_r[7];
              cnt_nxt   = 4'h1;
            end
          end
        end
        i2c_port_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_r != i2c_port_pkg::BYTE_BITS) begin
              txsh_nxt  = {txsh_r[6:0], 1'b0};
              drive_nxt = ~txsh_r[6];
              cnt_nxt   = cnt_r + 4'h1;
            end else begin
              drive_nxt = 1'b0;
              state_nxt = i2c_port_pkg::ST_TX_ACK;
            end
          end
        end
        i2c_port_pkg::ST_TX_ACK: begin
          // master nack ends the read; ack reloads on next fall
          if (scl_rise) begin
            after_nxt = i2c_port_pkg::ST_TX;
            state_nxt = sda_s ? i2c_port_pkg::ST_WAIT : i2c_port_pkg::ST_ACK;
          end
        end
        i2c_port_pkg::ST_IDLE, i2c_port_pkg::ST_WAIT: begin
          drive_nxt = 1'b0;
        end
        default: begin
          state_nxt = i2c_port_pkg::ST_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  // flags: hardware set wins over software clear
  always_comb begin
    txbuf_nxt = TX_LOAD_I ? TX_DATA_I : txbuf_r;
    ovf_nxt   = (ovf_r & ~OVF_CLR_I) | (take & ~fifo_ready);
    irq_nxt   = (irq_r & ~IRQ_CLR_I) | take |
                (PORT_ENABLE_I & has_ss(MODE_I) & (start_det | stop_det));
    ss_nxt    = PORT_ENABLE_I & (start_det | (ss_r & ~stop_det));
    sp_nxt    = PORT_ENABLE_I & (stop_det | (sp_r & ~start_det));
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_r    <= i2c_port_pkg::ST_IDLE;
      after_r    <= i2c_port_pkg::ST_IDLE;
      shift_r    <= i2c_port_pkg::SHIFT_RST;
      txsh_r     <= i2c_port_pkg::TX_RST;
      txbuf_r    <= i2c_port_pkg::TX_RST;
      cnt_r      <= i2c_port_pkg::CNT_RST;
      drive_r    <= 1'b0;
      hi_match_r <= 1'b0;
      ovf_r      <= 1'b0;
      irq_r      <= 1'b0;
      ss_r       <= 1'b0;
      sp_r       <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      after_r    <= after_nxt;
      shift_r    <= shift_nxt;
      txsh_r     <= txsh_nxt;
      txbuf_r    <= txbuf_nxt;
      cnt_r      <= cnt_nxt;
      drive_r    <= drive_nxt;
      hi_match_r <= hi_match_nxt;
      ovf_r      <= ovf_nxt;
      irq_r      <= irq_nxt;
      ss_r       <= ss_nxt;
      sp_r       <= sp_nxt;
    end
  end

  // open drain: only ever pull low; clock is never stretched
  assign SCL_O        = 1'b0;
  assign SCL_OE_O     = 1'b0;
  assign SDA_O        = 1'b0;
  assign SDA_OE_O     = drive_r & active & pins_ok;
  assign OVERFLOW_O   = ovf_r;
  assign IRQ_FLAG_O   = irq_r;
  assign START_SEEN_O = ss_r;
  assign STOP_SEEN_O  = sp_r;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_OFF_NO_DRIVE: assert property (!PORT_ENABLE_I |-> !SDA_OE_O)
    else $error("data pin driven while port disabled");
  AST_DIR_GATE: assert property (!(SCL_DIR_IN_I && SDA_DIR_IN_I) |-> !SDA_OE_O)
    else $error("data pin driven with direction not input");
  AST_PUSH_ACKS: assert property (push |=> state_r == i2c_port_pkg::ST_ACK && drive_r)
    else $error("stored byte not acknowledged");
  AST_REFUSE_NACK: assert property (take && (!fifo_ready || ovf_r) |=> !drive_r)
    else $error("acknowledge given with buffer full or overflow");
  AST_REFUSE_NOLOAD: assert property (take && !fifo_ready |-> !push)
    else $error("byte loaded into full buffer");
  AST_IRQ_ON_BYTE: assert property (take |=> IRQ_FLAG_O ##1 (IRQ_FLAG_O || $past(IRQ_CLR_I)))
    else $error("interrupt flag not raised for byte");
  AST_OVF_STICKY: assert property (OVERFLOW_O && !OVF_CLR_I |=> OVERFLOW_O)
    else $error("overflow cleared without software");
  AST_SS_IRQ: assert property (start_det && PORT_ENABLE_I && has_ss(MODE_I) |=> IRQ_FLAG_O)
    else $error("start not flagged in interrupt mode");
  AST_SP_IRQ: assert property (stop_det && PORT_ENABLE_I && has_ss(MODE_I) |=> IRQ_FLAG_O)
    else $error("stop not flagged in interrupt mode");
  AST_OVF_SET: assert property (take && !fifo_ready |=> OVERFLOW_O)
    else $error("overflow not set for byte refused by full buffer");
  // master must see its own acknowledge bit, so the data pin is free here
  AST_TX_RELEASE: assert property (state_r == i2c_port_pkg::ST_TX_ACK |-> !drive_r)
    else $error("data pin held during master acknowledge slot");
  AST_ACK_RELEASE: assert property (state_r == i2c_port_pkg::ST_ACK && scl_fall && active &&
      !start_det && !stop_det && after_r != i2c_port_pkg::ST_TX |=> !drive_r)
    else $error("acknowledge not released after ninth clock");
  AST_ADDR7_MATCH: assert property (push && state_r == i2c_port_pkg::ST_ADDR &&
      !is_ten(MODE_I) |-> shift_r[7:1] == SLAVE_ADDR_I[6:0])
    else $error("acknowledged a foreign address");
endmodule

// ---- i2c_port_pkg.sv ----
// constants, modes and states for the two-wire slave port
// assumes one 200 MHz clock domain and a synchronous active-high reset
package i2c_port_pkg;
  // mode field encodings (4-bit control field)
  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_SS_ONLY  = 4'hB;
  localparam logic [3:0] MODE_SLV7_SS  = 4'hE;
  localparam logic [3:0] MODE_SLV10_SS = 4'hF;
  // 10-bit address header prefix
  localparam logic [4:0] ADDR10_PREFIX = 5'h1E;
  // bits per byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         RX_DEPTH      = 2;
  localparam int         DATA_W        = 8;
  localparam int         SYNC_STAGES   = 2;
  // reset values
  localparam logic [7:0] SHIFT_RST     = 8'h00;
  localparam logic [7:0] TX_RST        = 8'hFF;
  localparam logic [3:0] CNT_RST       = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_ACK, ST_TX, ST_TX_ACK, ST_WAIT
  } state_t;
endpackage

// ---- bit_sync.sv ----
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to CLOCK_I
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;

  // first stage is read only by the second
  always_comb begin
    meta_nxt = d_i;
  end

  // idle bus level is high, so reset to ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= meta_r;
    end
  end
  assign q_o = q_r;
endmodule

// ---- rx_buffer.sv ----
// small valid/ready fifo holding received bytes
// assumes both sides on the same clock
`timescale 1ns/1ps
module rx_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic      [W-1:0] out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // counter is one bit wider than the pointers, so DEPTH itself fits
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready_o  = (cnt_r != FULL_CNT);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // pointer wrap at DEPTH, not a power of two
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    if (pop)  rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    if (push && !pop) cnt_nxt = cnt_r + (AW+1)'(1);
    if (pop && !push) cnt_nxt = cnt_r - (AW+1)'(1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset
  always_ff @(posedge clk_i) begin
    if (push) mem_r[wp_r] <= in_data_i;
  end
endmodule

// ---- i2c_master_model.sv ----
// behavioural two-wire bus master: clock and data, open-drain style
// assumes pull-ups outside; bus_sda_i is the resolved data wire
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic bus_sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  localparam time Q = 40ns; // quarter of the 160 ns bus clock period

  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask

  // stop: data rises while clock is high, clock then stands still
  task automatic stop();
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #Q;
  endtask

  // one bit: data changes only while the clock is low
  task automatic put_bit(input logic b, output logic s);
    #Q sda_low_o = ~b;
    #Q scl_o = 1'b1;
    #Q s = bus_sda_i;
    #Q scl_o = 1'b0;
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
    put_bit(ack_in, ack);
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the two-wire slave port
// assumes the master model drives the bus; pull-ups resolved here
`timescale 1ns/1ps
module tb;
  logic       clk, rst, en, sdir, ddir, txl, rxr, ovc, irqc;
  logic [3:0] mode;
  logic [7:0] txd, rxd, lfsr, rq;
  logic       rxv, bf, ov, irq, sts, sps, scl_o, scl_oe, sda_o, sda_oe;
  logic       scl_m, sda_low, ra, ssm, ack7;
  logic [7:0] exp_q[$];
  logic [3:0] modes[5];
  int         num_errors = 0;
  int         compares = 0;
  // open-drain wires with pull-ups
  wire        sda = ~(sda_low | sda_oe);
  wire        scl = scl_m & ~scl_oe;

  i2c_master_model i2c_master_model_inst (.bus_sda_i(sda), .scl_o(scl_m), .sda_low_o(sda_low));
  i2c_slave_port i2c_slave_port_inst (
    .CLOCK_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SCL_O(scl_o),
    .SCL_OE_O(scl_oe), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .PORT_ENABLE_I(en),
    .MODE_I(mode), .SCL_DIR_IN_I(sdir), .SDA_DIR_IN_I(ddir),
    .SLAVE_ADDR_I(10'h35A), .TX_DATA_I(txd), .TX_LOAD_I(txl), .RX_DATA_O(rxd),
    .RX_VALID_O(rxv), .RX_READY_I(rxr), .BUFFER_FULL_O(bf), .OVERFLOW_O(ov),
    .OVF_CLR_I(ovc), .IRQ_FLAG_O(irq), .IRQ_CLR_I(irqc), .START_SEEN_O(sts),
    .STOP_SEEN_O(sps));

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle clear pulses, driven at the falling edge
  task automatic clr(input logic i, input logic o);
    @(negedge clk);
    irqc = i;
    ovc = o;
    @(negedge clk);
    irqc = 1'b0;
    ovc = 1'b0;
  endtask

  // send one byte; note it as expected in the queue only if it will be stored
  task automatic send(input logic [7:0] d, input logic want, input logic queued);
    logic [7:0] q;
    logic       a;
    if (queued) exp_q.push_back(d);
    i2c_master_model_inst.xfer(d, 1'b1, q, a);
    check("ack", a, !want);
  endtask

  function automatic logic [7:0] rnd();
    lfsr = next_rand(lfsr);
    return lfsr;
  endfunction

  // consumer side: oldest note checked against each popped byte
  always @(posedge clk) begin
    if (!rst && rxv === 1'b1 && rxr === 1'b1) begin
      if (exp_q.size() == 0) check("rx extra", 1, 0);
      else check("rx data", rxd, exp_q.pop_front());
    end
  end

  // watchdog sized well above the expected run of about 40 us
  initial begin
    #400us;
    num_errors++;
    results();
  end

  initial begin
    rst = 1'b1; en = 1'b1; sdir = 1'b1; ddir = 1'b1; txl = 1'b0; rxr = 1'b1;
    ovc = 1'b0; irqc = 1'b0; txd = 8'h00; mode = i2c_port_pkg::MODE_SLV7; lfsr = 8'h42;
    modes = '{i2c_port_pkg::MODE_SLV7, i2c_port_pkg::MODE_SLV10, i2c_port_pkg::MODE_SS_ONLY,
              i2c_port_pkg::MODE_SLV7_SS, i2c_port_pkg::MODE_SLV10_SS};
    clks(10);
    rst = 1'b0;
    check("valid after reset", rxv, 0);
    check("drive after reset", sda_oe, 0);
    clks(3);
    // plain 7-bit write with two random bytes
    i2c_master_model_inst.start();
    send(8'hB4, 1'b1, 1'b1);
    check("irq on ack", irq, 1);
    send(rnd(), 1'b1, 1'b1);
    send(rnd(), 1'b1, 1'b1);
    i2c_master_model_inst.stop();
    clks(20);
    check("queue drained", exp_q.size(), 0);
    check("unused pin drives", {scl_oe, scl_o, sda_o}, 3'h0);
    $display("test 1 done");
    // wrong address, then disabled port and output-direction data pin
    i2c_master_model_inst.start();
    send(8'hB6, 1'b0, 1'b0);
    send(rnd(), 1'b0, 1'b0);
    i2c_master_model_inst.stop();
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      en = k[0];
      ddir = ~k[0];
      i2c_master_model_inst.start();
      // data pin as output: byte still taken and stored, but never acknowledged
      send(8'hB4, 1'b0, k[0]);
      i2c_master_model_inst.stop();
    end
    en = 1'b1;
    ddir = 1'b1;
    $display("test 2 done");
    // receiver stalls: queue fills, then refusal and overflow
    rxr = 1'b0;
    i2c_master_model_inst.start();
    send(8'hB4, 1'b1, 1'b1);
    send(rnd(), 1'b1, 1'b1);
    check("full", bf, 1);
    clr(1'b1, 1'b0);
    send(rnd(), 1'b0, 1'b0);
    check("overflow", ov, 1);
    check("irq on refusal", irq, 1);
    send(rnd(), 1'b0, 1'b0);
    i2c_master_model_inst.stop();
    rxr = 1'b1;
    clks(10);
    check("full after read", bf, 0);
    check("overflow sticky", ov, 1);
    clr(1'b0, 1'b1);
    check("overflow cleared", ov, 0);
    $display("test 3 done");
    // 10-bit write and read, then 7-bit read, both by repeated start
    txd = rnd();
    txl = 1'b1;
    @(negedge clk);
    txl = 1'b0;
    mode = i2c_port_pkg::MODE_SLV10;
    i2c_master_model_inst.start();
    send(8'hF6, 1'b1, 1'b1);
    send(8'h5A, 1'b1, 1'b1);
    send(rnd(), 1'b1, 1'b1);
    i2c_master_model_inst.start();
    send(8'hF7, 1'b1, 1'b1);
    i2c_master_model_inst.xfer(8'hFF, 1'b1, rq, ra);
    check("read byte 10-bit", rq, txd);
    i2c_master_model_inst.stop();
    @(negedge clk);
    mode = i2c_port_pkg::MODE_SLV7;
    i2c_master_model_inst.start();
    send(8'hB4, 1'b1, 1'b1);
    i2c_master_model_inst.start();
    send(8'hB5, 1'b1, 1'b1);
    i2c_master_model_inst.xfer(8'hFF, 1'b1, rq, ra);
    check("read byte", rq, txd);
    i2c_master_model_inst.stop();
    $display("test 4 done");
    // every mode: start/stop interrupts and address response
    foreach (modes[m]) begin
      mode = modes[m];
      ssm  = (mode == i2c_port_pkg::MODE_SS_ONLY) || (mode == i2c_port_pkg::MODE_SLV7_SS) ||
             (mode == i2c_port_pkg::MODE_SLV10_SS);
      ack7 = (mode == i2c_port_pkg::MODE_SLV7) || (mode == i2c_port_pkg::MODE_SLV7_SS);
      clr(1'b1, 1'b0);
      i2c_master_model_inst.start();
      clks(2);
      check("start seen", sts, 1);
      check("start irq", irq, ssm);
      send(8'hB4, ack7, ack7);
      // drop the byte's flag so only the stop can raise it again
      clr(1'b1, 1'b0);
      i2c_master_model_inst.stop();
      clks(8);
      check("stop seen", sps, 1);
      check("stop irq", irq, ssm);
    end
    clks(20);
    check("queue drained", exp_q.size(), 0);
    $display("test 5 done");
    results();
  end
endmodule
